// >>> pkg/sarseq_pkg.sv
// Package for the successive-approximation converter sequencer.
// Assumes a single 20 MHz clock and an AXI4-Lite register bus.
package sarseq_pkg;

  // ****************************************
  // Register map
  // ****************************************
  // Printed offsets step by one, not by four: they are word indices
  localparam logic [7:0] SARSEQ_RESULT_IDX = 8'hD0;
  localparam logic [7:0] SARSEQ_CTRL_IDX = 8'hD1;
  localparam logic [7:0] SARSEQ_OPT_IDX = 8'hD2;
  localparam int SARSEQ_ADDR_W = 12;
  localparam logic [SARSEQ_ADDR_W-1:0] SARSEQ_RESULT_ADDR = {2'h0, SARSEQ_RESULT_IDX, 2'h0};
  localparam logic [SARSEQ_ADDR_W-1:0] SARSEQ_CTRL_ADDR = {2'h0, SARSEQ_CTRL_IDX, 2'h0};
  localparam logic [SARSEQ_ADDR_W-1:0] SARSEQ_OPT_ADDR = {2'h0, SARSEQ_OPT_IDX, 2'h0};

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int SARSEQ_IE_BIT = 7;
  localparam int SARSEQ_DONE_BIT = 6;
  localparam int SARSEQ_START_BIT = 5;
  localparam int SARSEQ_PWR_BIT = 4;
  localparam int SARSEQ_SYNC_BIT = 0;
  localparam logic [7:0] SARSEQ_CTRL_RESET = 8'h40;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SARSEQ_CLK_HZ = 20000000;
  localparam int SARSEQ_OSC_DIV = 12;
  localparam int SARSEQ_RES_BITS = 8;
  localparam int SARSEQ_CONV_NS = 70000;
  localparam int SARSEQ_REF_OSC_HZ = 8000000;
  // Conversion time in divided-clock ticks at the reference oscillator
  localparam int SARSEQ_CONV_TICKS = (SARSEQ_CONV_NS / 1000) * (SARSEQ_REF_OSC_HZ / 1000000) / SARSEQ_OSC_DIV;
  // Divided ticks per result bit, rounded down, at least one
  localparam int SARSEQ_TICKS_PER_BIT = (SARSEQ_CONV_TICKS / SARSEQ_RES_BITS) > 0 ?
                                        (SARSEQ_CONV_TICKS / SARSEQ_RES_BITS) : 1;

  localparam logic [1:0] SARSEQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] SARSEQ_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SARSEQ_IDLE, SARSEQ_ARM, SARSEQ_STEP} sarseq_state_t;

  // Control bits that travel together
  typedef struct packed {
    logic ie;
    logic pwr;
    logic sync;
  } sarseq_ctrl_t;

  // Comparator interface to the analog side
  typedef struct packed {
    logic [SARSEQ_RES_BITS-1:0] trial;
    logic sample;
  } sarseq_dac_t;

endpackage

// >>> design/sarseq_divider.sv
// Tick generator: one-cycle tick every DIV cycles of aclk.
// Assumes clear restarts the count so a restart is aligned.
module sarseq_divider
  import sarseq_pkg::*;
#(
  parameter int DIV = SARSEQ_OSC_DIV * SARSEQ_TICKS_PER_BIT
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic clear,
  output logic tick
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  // ****************************************
  // Divided step clock
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear || !run)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q == LAST)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tick = run && !clear && (cnt_q == LAST);

endmodule // sarseq_divider

// >>> design/sarseq_top.sv
// Successive-approximation converter sequencer with AXI4-Lite registers.
// Assumes an external comparator and DAC, and a core wait-mode status pin.
//
// Behaviour
// - Produce an 8-bit result per conversion by successive approximation.
// - Step clock is the oscillator divided by twelve.
// - Conversion takes about 70 us at 8 MHz, scaled by divided clock; the code takes 40 divided ticks, 60 us at 8 MHz.
// - Writing start one begins conversion and clears done flag.
// - Completion sets done flag; result register then valid.
// - Single-shot: idle after completion until start written again.
// - Start during conversion abandons it and begins a new one.
// - Start bit is write-only and reads as zero.
// - Done flag requests vector-four interrupt unless enable is clear.
// - Power bit zero powers down; one powers and enables conversions.
// - Wait mode does not switch off the comparator.
// - Reset stops conversion, control becomes 40h, interrupt masked.
// - Done interrupt can wake the processor from wait mode.
// - Sleep-aligned option holds first step until core is in wait.
// - Result register is read-only at 0D0h with last result.
// - Control at 0D1h: enable, done, start, power; low bits unused.
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int RES_BITS = SARSEQ_RES_BITS
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [SARSEQ_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [SARSEQ_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog side
  input wire logic comp_in,
  output logic [RES_BITS-1:0] dac_trial,
  output logic conv_active,
  output logic analog_power,
  // Core side
  input wire logic core_in_wait,
  output logic irq_vec4
);

  sarseq_state_t state_q;
  sarseq_ctrl_t ctrl_q;
  logic done_q;
  logic [RES_BITS-1:0] result_q;
  logic [RES_BITS-1:0] trial_q;
  logic [$clog2(RES_BITS)-1:0] bit_q;
  logic [2:0] comp_sync_q;
  logic comp_q;
  logic [2:0] wait_sync_q;
  logic wait_q;
  logic aw_held_q;
  logic w_held_q;
  logic [SARSEQ_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic start_pulse;
  logic wr_fire;
  logic step_tick;
  logic finish;

  // Byte lane zero write of control register
  function automatic logic ctrl_write(input logic [SARSEQ_ADDR_W-1:0] a, input logic [3:0] s);
    ctrl_write = (a == SARSEQ_CTRL_ADDR) && s[0];
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Change accepted once second and third stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      comp_sync_q <= '0;
      comp_q <= 1'b0;
    end
    else
    begin
      comp_sync_q <= {comp_sync_q[1:0], comp_in};
      if (comp_sync_q[1] == comp_sync_q[2])
      begin
        comp_q <= comp_sync_q[2];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wait_sync_q <= '0;
      wait_q <= 1'b0;
    end
    else
    begin
      wait_sync_q <= {wait_sync_q[1:0], core_in_wait};
      if (wait_sync_q[1] == wait_sync_q[2])
      begin
        wait_q <= wait_sync_q[2];
      end
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data taken in either order; response after both
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SARSEQ_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Result register is read-only, so writing it is an error
        s_axi_bresp <= (awaddr_q == SARSEQ_CTRL_ADDR || awaddr_q == SARSEQ_OPT_ADDR) ?
                       SARSEQ_RESP_OKAY : SARSEQ_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign start_pulse = wr_fire && ctrl_write(awaddr_q, wstrb_q) && wdata_q[SARSEQ_START_BIT];

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q.ie <= SARSEQ_CTRL_RESET[SARSEQ_IE_BIT];
      ctrl_q.pwr <= SARSEQ_CTRL_RESET[SARSEQ_PWR_BIT];
      ctrl_q.sync <= 1'b0;
    end
    else if (wr_fire && wstrb_q[0])
    begin
      if (awaddr_q == SARSEQ_CTRL_ADDR)
      begin
        ctrl_q.ie <= wdata_q[SARSEQ_IE_BIT];
        ctrl_q.pwr <= wdata_q[SARSEQ_PWR_BIT];
      end
      if (awaddr_q == SARSEQ_OPT_ADDR)
      begin
        ctrl_q.sync <= wdata_q[SARSEQ_SYNC_BIT];
      end
    end
  end

  // ****************************************
  // Done flag
  // ****************************************
  // Completion and a start cannot meet: a start aborts the conversion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_q <= SARSEQ_CTRL_RESET[SARSEQ_DONE_BIT];
    end
    else if (finish)
    begin
      done_q <= 1'b1;
    end
    else if (start_pulse)
    begin
      done_q <= 1'b0;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  sarseq_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_q == SARSEQ_STEP),
    .clear(start_pulse),
    .tick(step_tick)
  );

  assign finish = (state_q == SARSEQ_STEP) && step_tick && (bit_q == '0) && !start_pulse;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= SARSEQ_IDLE;
    end
    else
    begin
      case (state_q)
        SARSEQ_IDLE:
        begin
          if (start_pulse && ctrl_q.pwr)
          begin
            state_q <= SARSEQ_ARM;
          end
        end
        SARSEQ_ARM:
        begin
          if (start_pulse && !ctrl_q.pwr)
          begin
            state_q <= SARSEQ_IDLE;
          end
          else if (!ctrl_q.pwr)
          begin
            state_q <= SARSEQ_IDLE;
          end
          else if (!start_pulse && (!ctrl_q.sync || wait_q))
          begin
            state_q <= SARSEQ_STEP;
          end
        end
        SARSEQ_STEP:
        begin
          if (!ctrl_q.pwr)
          begin
            state_q <= SARSEQ_IDLE;
          end
          else if (start_pulse)
          begin
            state_q <= SARSEQ_ARM;
          end
          else if (finish)
          begin
            state_q <= SARSEQ_IDLE;
          end
        end
        default:
        begin
          state_q <= SARSEQ_IDLE;
        end
      endcase
    end
  end

  // Trial word: set next bit, keep or drop current by comparator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trial_q <= '0;
      bit_q <= '0;
    end
    else if (start_pulse)
    begin
      trial_q <= {1'b1, {(RES_BITS-1){1'b0}}};
      bit_q <= ($clog2(RES_BITS))'(RES_BITS - 1);
    end
    else if (state_q == SARSEQ_STEP && step_tick)
    begin
      // Comparator high means input below trial: drop the bit
      if (comp_q)
      begin
        trial_q[bit_q] <= 1'b0;
      end
      if (bit_q != '0)
      begin
        trial_q[bit_q - 1'b1] <= 1'b1;
        bit_q <= bit_q - 1'b1;
      end
    end
  end

  // Result only on completion so an abort keeps the old value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_q <= '0;
    end
    else if (finish)
    begin
      result_q <= comp_q ? (trial_q & ~(RES_BITS'(1))) : trial_q;
    end
  end

  // ****************************************
  // Outputs to analog side and core
  // ****************************************
  // Power follows only the bit, not wait mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      analog_power <= 1'b0;
      dac_trial <= '0;
      conv_active <= 1'b0;
      irq_vec4 <= 1'b0;
    end
    else
    begin
      analog_power <= ctrl_q.pwr;
      dac_trial <= trial_q;
      conv_active <= (state_q == SARSEQ_STEP);
      // Level request; also serves as the wake source from wait
      irq_vec4 <= done_q && ctrl_q.ie;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SARSEQ_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= SARSEQ_RESP_OKAY;
        s_axi_rdata <= '0;
        case (s_axi_araddr)
          SARSEQ_RESULT_ADDR:
          begin
            s_axi_rdata[RES_BITS-1:0] <= result_q;
          end
          SARSEQ_CTRL_ADDR:
          begin
            // Start position always reads zero
            s_axi_rdata[SARSEQ_IE_BIT] <= ctrl_q.ie;
            s_axi_rdata[SARSEQ_DONE_BIT] <= done_q;
            s_axi_rdata[SARSEQ_START_BIT] <= 1'b0;
            s_axi_rdata[SARSEQ_PWR_BIT] <= ctrl_q.pwr;
          end
          SARSEQ_OPT_ADDR:
          begin
            s_axi_rdata[SARSEQ_SYNC_BIT] <= ctrl_q.sync;
          end
          default:
          begin
            s_axi_rresp <= SARSEQ_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sarseq_top

// >>> verification/sarseq_chk_assertions.sv
// Port checker for the converter sequencer.
// Assumes one clock domain and aresetn synchronous, active low.
module sarseq_chk
  import sarseq_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter
  input wire logic conv_active,
  input wire logic analog_power,
  input wire logic irq_vec4
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Assertions
  // ****
  localparam int CONV = SARSEQ_RES_BITS * SARSEQ_OSC_DIV * SARSEQ_TICKS_PER_BIT;
  logic [9:0] cnt_q;
  // Cleared by a write so a restart begins a fresh count
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !conv_active || s_axi_bvalid)
      cnt_q <= 10'h0;
    else
      cnt_q <= cnt_q + 10'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_RESET_QUIET: assert property (disable iff (1'h0) !aresetn |=> !conv_active && !irq_vec4 && !analog_power)
    else $error("outputs active after reset");
  AST_START_POWERED: assert property ($rose(conv_active) |-> analog_power)
    else $error("conversion started unpowered");
  AST_START_NO_IRQ: assert property ($rose(conv_active) |-> ##1 !irq_vec4 [*8])
    else $error("interrupt during conversion");
  AST_CONV_CYCLES: assert property (conv_active |-> cnt_q <= CONV)
    else $error("conversion too long");
  AST_POWER_ABORT: assert property ($fell(analog_power) |-> ##[0:2] !conv_active)
    else $error("conversion survives power down");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed");
  AST_WRITE_ANSWER: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule // sarseq_chk

bind sarseq_top sarseq_chk u_chk (.*);

// >>> verification/sarseq_analog.sv
// Model of the one selected analog pin and its comparator.
// Assumes the trial code settles within a clock cycle.
module sarseq_analog
  import sarseq_pkg::*;
(
  // Pin level and trial code
  input wire logic [SARSEQ_RES_BITS-1:0] level,
  input wire logic [SARSEQ_RES_BITS-1:0] trial,
  // Comparator
  output logic comp
);
  timeunit 1ns;
  timeprecision 1ns;
  // Single level: only one pin selected at a time
  assign comp = (level < trial);
endmodule // sarseq_analog

// >>> verification/testbench.sv
// Self-checking bench for the converter sequencer.
// Assumes the analog model and the bound port checker.
module testbench
  import sarseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Stimulus and checks
  // ****
  localparam int CONV = SARSEQ_RES_BITS * SARSEQ_OSC_DIV * SARSEQ_TICKS_PER_BIT;
  localparam logic [11:0] C = SARSEQ_CTRL_ADDR;
  localparam logic [11:0] R = SARSEQ_RESULT_ADDR;
  localparam logic [1:0] OK = SARSEQ_RESP_OKAY;
  localparam logic [1:0] ERR = SARSEQ_RESP_SLVERR;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic core_in_wait = 1'h0;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] level = 8'h0, dac_trial;
  logic awready, wready, bvalid, arready, rvalid, comp_in, conv_active, analog_power, irq_vec4;
  logic [1:0] bresp, rresp;
  logic [31:0] d;
  logic [7:0] lv [3] = '{8'h00, 8'hFF, 8'hA5};
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n, t0;
  always #25 aclk = ~aclk;
  sarseq_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comp_in(comp_in),
    .dac_trial(dac_trial), .conv_active(conv_active), .analog_power(analog_power),
    .core_in_wait(core_in_wait), .irq_vec4(irq_vec4));
  sarseq_analog u_pin (.level(level), .trial(dac_trial), .comp(comp_in));
  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'h1)
        awvalid <= 1'h0;
      if (wready === 1'h1)
        wvalid <= 1'h0;
    end while ((awvalid && awready !== 1'h1) || (wvalid && wready !== 1'h1));
    bready <= 1'h1;
    do
      @(posedge aclk);
    while (bvalid !== 1'h1);
    cmp("bresp", er, bresp);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do
      @(posedge aclk);
    while (arready !== 1'h1);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do
      @(posedge aclk);
    while (rvalid !== 1'h1);
    v = rdata;
    cmp("rresp", er, rresp);
    rready <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, OK, v);
    cmp(nm, e, v);
  endtask
  // Bounded wait from a cycle stamp, so reads in between do not shorten the count
  task automatic wait_done(input int s, output int k);
    while (irq_vec4 !== 1'h1 && cyc - s < 2000)
      @(posedge aclk);
    k = cyc - s;
  endtask
  // Updated late in the step so tasks read a settled count at each edge
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    chk("ctrl", C, 32'h40);
    wr(C, 8'h10, OK);
    chk("ctrl", C, 32'h50);
    wstrb <= 4'hE;
    wr(C, 8'hB0, OK);
    wstrb <= 4'hF;
    chk("ctrl", C, 32'h50);
    cmp("active", 0, conv_active);
    foreach (lv[i])
    begin
      level <= lv[i];
      wr(C, 8'hB0, OK);
      t0 = cyc;
      chk("ctrl", C, 32'h90);
      wait_done(t0, n);
      cmp("conv_time", 1, n >= CONV && n <= CONV + 8);
      chk("result", R, {24'h0, lv[i]});
      chk("ctrl", C, 32'hD0);
    end
    repeat (600) @(posedge aclk);
    cmp("active", 0, conv_active);
    level <= 8'h3C;
    wr(C, 8'hB0, OK);
    repeat (200) @(posedge aclk);
    level <= 8'hC3;
    wr(C, 8'hB0, OK);
    wait_done(cyc, n);
    cmp("conv_time", 1, n >= CONV && n <= CONV + 8);
    chk("result", R, 32'hC3);
    level <= 8'h11;
    wr(C, 8'h30, OK);
    repeat (100) @(posedge aclk);
    wr(C, 8'h00, OK);
    repeat (600) @(posedge aclk);
    chk("ctrl", C, 32'h00);
    chk("result", R, 32'hC3);
    cmp("power", 0, analog_power);
    wr(C, 8'h10, OK);
    wr(C, 8'h30, OK);
    repeat (CONV + 20) @(posedge aclk);
    chk("ctrl", C, 32'h50);
    cmp("irq", 0, irq_vec4);
    chk("result", R, 32'h11);
    wr(C, 8'h90, OK);
    repeat (2) @(posedge aclk);
    cmp("irq", 1, irq_vec4);
    wr(SARSEQ_OPT_ADDR, 8'h01, OK);
    level <= 8'h5A;
    wr(C, 8'hB0, OK);
    repeat (300) @(posedge aclk);
    cmp("active", 0, conv_active);
    chk("ctrl", C, 32'h90);
    core_in_wait <= 1'h1;
    wait_done(cyc, n);
    cmp("conv_time", 1, n >= CONV && n <= CONV + 8);
    cmp("power", 1, analog_power);
    core_in_wait <= 1'h0;
    wr(R, 8'h55, ERR);
    chk("result", R, 32'h5A);
    rd(12'h100, ERR, d);
    cmp("unmapped", 0, d);
    wr(SARSEQ_OPT_ADDR, 8'h00, OK);
    wr(C, 8'hB0, OK);
    repeat (100) @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    cmp("active", 0, conv_active);
    cmp("irq", 0, irq_vec4);
    cmp("trial", 0, dac_trial);
    chk("ctrl", C, 32'h40);
    wr(C, 8'hA0, OK);
    chk("ctrl", C, 32'h80);
    repeat (CONV + 20) @(posedge aclk);
    cmp("active", 0, conv_active);
    cmp("irq", 0, irq_vec4);
    conclude();
  end
endmodule // testbench
